//--- core/smp_defs.vh
// Purpose: constants for the shared pin priority mux
// Assumes: 8-bit register port, 4-bit address
// Notes:   owner codes count from the highest priority function down
// How it works
// RQ1: after reset every shared pin is a port input, whatever is enabled; pins are held as inputs only until the first edge after reset release.
// RQ2: A0/A1 order: analog channel, timer-one channel, keypad input, port.
// RQ3: A2 order: external interrupt, timer-one clock, keypad input, input-only port.
// RQ4: A4/A5 order: oscillator output/input, analog channel, keypad input, port.
// RQ5: B0 order: analog channel, serial peripheral clock line, port.
// RQ6: B1/B2 order: analog channel, serial data line, timer-two channel, port.
// RQ7: B3 order: analog channel, slave select, timer-two clock, port.
// RQ8: B4/B5 order: analog channel, async serial line, relocated timer-two channel, port.
// RQ9: async serial transmit only drives its pin; receive only listens.
// RQ10: relocate bit puts timer-two channels on B1/B2 or on B5/B4.
// RQ11: analog channel takes ownership but does not stop other sharers driving.
// RQ12: high-voltage detectors on A2 and C3 enter special modes.
// RQ13: software terminates unused pins as driven outputs or pulled-up inputs.
// RQ14: A3 order: reset input, keypad input, port; B6/B7: timer-one channel, port.
// RQ15: highest enabled function sets direction and output combinationally.
`ifndef SMP_DEFS_VH
`define SMP_DEFS_VH

`define SMP_ADDR_W          4
`define SMP_DATA_W          8

`define SMP_REG_PA_DATA     4'h0
`define SMP_REG_PA_DIR      4'h1
`define SMP_REG_PB_DATA     4'h2
`define SMP_REG_PB_DIR      4'h3
`define SMP_REG_SECOND_CFG  4'h4
`define SMP_REG_PA_LEVEL    4'h5
`define SMP_REG_OWNER0      4'h6
`define SMP_REG_OWNER1      4'h7
`define SMP_REG_OWNER2      4'h8
`define SMP_REG_OWNER3      4'h9
`define SMP_REG_PB_LEVEL    4'ha
`define SMP_REG_STATUS      4'hb

`define SMP_CFG2_RELOC_BIT  0
`define SMP_RESET_VALUE     8'h00

`define SMP_PIN_COUNT       14
`define SMP_FUNC_COUNT      4

`endif

//--- core/smp_pin_resolve.v
// Purpose: one pin's priority resolver
// Assumes: slot 0 is the highest priority, the port is the lowest-priority slot in use
// Notes:   analog slots claim ownership but never drive the pin
`timescale 1ns/1ps
module smp_pin_resolve #(
    parameter       N           = 4,
    parameter [3:0] ANALOG_MASK = 4'h0
) (
    input  wire [N-1:0] func_en_in,
    input  wire [N-1:0] func_oe_in,
    input  wire [N-1:0] func_out_in,
    output reg  [1:0]   owner_out,
    output reg          pin_oe_out,
    output reg          pin_out
);

    integer i;

    // walk down from slot N-1 to slot 0 so the highest enabled slot is the last to write
    always @*
    begin
        owner_out  = 2'h3;
        pin_oe_out = 1'b0;
        pin_out    = 1'b0;
        for (i = N - 1; i >= 0; i = i - 1)
        begin
            if (func_en_in[i])
            begin
                owner_out = i[1:0]; // [RQ15]
                if (!ANALOG_MASK[i])
                begin
                    // an analog winner leaves the drive to the next sharer [RQ11]
                    pin_oe_out = func_oe_in[i];
                    pin_out    = func_out_in[i];
                end
            end
        end
    end

endmodule // smp_pin_resolve

//--- core/smp_hv_detect.v
// Purpose: high-voltage detectors for the special-mode pins
// Assumes: detector levels arrive synchronous to clock_in
// Notes:   a flag stays set until the next reset
`timescale 1ns/1ps
module smp_hv_detect (
    input  wire       clock_in,
    input  wire       rst_in,
    input  wire       hv_a2_in,
    input  wire       hv_c3_in,
    output wire [1:0] special_mode_out
);

    reg [1:0] seen_q;

    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            seen_q <= 2'h0;
        else
            seen_q <= seen_q | {hv_c3_in, hv_a2_in}; // [RQ12]
    end

    assign special_mode_out = seen_q;

endmodule // smp_hv_detect

//--- core/smp_shared_pin_priority_mux.v
// Purpose: priority multiplexer for the shared port A and port B pins
// Assumes: peripheral enables and drives are synchronous to clock_in
// Notes:   pins are forced to input during reset and one cycle after it
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "smp_defs.vh"
module smp_shared_pin_priority_mux (
    input  wire                   clock_in,
    input  wire                   rst_in,
    input  wire [`SMP_ADDR_W-1:0] addr_in,
    input  wire [`SMP_DATA_W-1:0] wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    output reg  [`SMP_DATA_W-1:0] rdata_out,
    input  wire [9:0]             analog_channel_en_in,
    input  wire [5:0]             keypad_irq_en_in,
    input  wire [3:0]             timer_one_channel_en_in,
    input  wire [3:0]             timer_one_channel_oe_in,
    input  wire [3:0]             timer_one_channel_out_in,
    input  wire [1:0]             timer_two_channel_en_in,
    input  wire [1:0]             timer_two_channel_oe_in,
    input  wire [1:0]             timer_two_channel_out_in,
    input  wire                   timer_one_ext_clock_en_in,
    input  wire                   timer_two_ext_clock_en_in,
    input  wire                   ext_irq_en_in,
    input  wire                   reset_pin_en_in,
    input  wire                   oscillator_output_en_in,
    input  wire                   oscillator_output_clk_in,
    input  wire                   oscillator_input_en_in,
    input  wire                   spi_en_in,
    input  wire                   serial_periph_clock_line_oe_in,
    input  wire                   serial_periph_clock_line_out_in,
    input  wire                   spi_mosi_oe_in,
    input  wire                   spi_mosi_out_in,
    input  wire                   spi_miso_oe_in,
    input  wire                   spi_miso_out_in,
    input  wire                   spi_slave_select_en_in,
    input  wire                   async_serial_rx_en_in,
    input  wire                   async_serial_tx_en_in,
    input  wire                   async_serial_tx_out_in,
    input  wire [5:0]             port_a_pin_in,
    output wire [5:0]             port_a_pin_out,
    output wire [5:0]             port_a_oe_out,
    input  wire [7:0]             port_b_pin_in,
    output wire [7:0]             port_b_pin_out,
    output wire [7:0]             port_b_oe_out,
    input  wire                   port_a_bit_two_hv_in,
    input  wire                   port_c_bit_three_hv_in,
    output wire [1:0]             special_mode_out
);

    localparam NP = `SMP_PIN_COUNT;
    localparam NF = `SMP_FUNC_COUNT;

    // analog slots per pin, pin 0..5 = A0..A5, pin 6..13 = B0..B7
    localparam [4*NP-1:0] ANA_MAP = {4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1,
                                     4'h2, 4'h2, 4'h0, 4'h0, 4'h1, 4'h1};

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    reg [5:0] pa_data_q;
    reg [5:0] pa_dir_q;
    reg [7:0] pb_data_q;
    reg [7:0] pb_dir_q;
    reg       timer_two_relocate_bit_q;
    reg       ready_q;
    reg [`SMP_DATA_W-1:0] rdata_d;

    wire [2*NP-1:0] owner;
    wire [NP-1:0]   res_oe;
    wire [NP-1:0]   res_out;

    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pa_data_q                <= 6'h00; // [RQ1]
            pa_dir_q                 <= 6'h00; // [RQ1]
            pb_data_q                <= `SMP_RESET_VALUE;
            pb_dir_q                 <= `SMP_RESET_VALUE; // [RQ1]
            timer_two_relocate_bit_q <= 1'b0;
            ready_q                  <= 1'b0;
            rdata_out                <= `SMP_RESET_VALUE;
        end
        else
        begin
            ready_q   <= 1'b1;
            rdata_out <= rdata_d;
            if (wr_in)
            begin
                case (addr_in)
                    `SMP_REG_PA_DATA: pa_data_q <= wdata_in[5:0];
                    `SMP_REG_PA_DIR:  pa_dir_q  <= wdata_in[5:0];
                    `SMP_REG_PB_DATA: pb_data_q <= wdata_in;
                    `SMP_REG_PB_DIR:  pb_dir_q  <= wdata_in;
                    `SMP_REG_SECOND_CFG: timer_two_relocate_bit_q <= wdata_in[`SMP_CFG2_RELOC_BIT];
                    default:          ready_q <= 1'b1;
                endcase
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always @*
    begin
        rdata_d = `SMP_RESET_VALUE;
        if (rd_in)
        begin
            case (addr_in)
                `SMP_REG_PA_DATA:  rdata_d = {2'h0, pa_data_q};
                `SMP_REG_PA_DIR:   rdata_d = {2'h0, pa_dir_q};
                `SMP_REG_PB_DATA:  rdata_d = pb_data_q;
                `SMP_REG_PB_DIR:   rdata_d = pb_dir_q;
                `SMP_REG_SECOND_CFG: rdata_d = {7'h00, timer_two_relocate_bit_q};
                `SMP_REG_PA_LEVEL: rdata_d = {2'h0, port_a_pin_in};
                `SMP_REG_OWNER0:   rdata_d = owner[7:0];
                `SMP_REG_OWNER1:   rdata_d = owner[15:8];
                `SMP_REG_OWNER2:   rdata_d = owner[23:16];
                `SMP_REG_OWNER3:   rdata_d = {4'h0, owner[27:24]};
                `SMP_REG_PB_LEVEL: rdata_d = port_b_pin_in;
                `SMP_REG_STATUS:   rdata_d = {6'h00, special_mode_out};
                default:           rdata_d = `SMP_RESET_VALUE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // function slots per pin, slot 0 highest priority

    reg [NF*NP-1:0] en;
    reg [NF*NP-1:0] oe;
    reg [NF*NP-1:0] dout;
    wire            t2_on_b12;
    wire            t2_on_b54;

    assign t2_on_b12 = ~timer_two_relocate_bit_q; // [RQ10]
    assign t2_on_b54 = timer_two_relocate_bit_q;  // [RQ10]

    always @*
    begin
        en   = {NF*NP{1'b0}};
        oe   = {NF*NP{1'b0}};
        dout = {NF*NP{1'b0}};
        // A0 and A1 [RQ2]
        en[3:0]    = {1'b1,
                      keypad_irq_en_in[0],
                      timer_one_channel_en_in[0],
                      analog_channel_en_in[0]};
        oe[3:0]    = {pa_dir_q[0],
                      1'b0,
                      timer_one_channel_oe_in[0],
                      1'b0};
        dout[3:0]  = {pa_data_q[0],
                      1'b0,
                      timer_one_channel_out_in[0],
                      1'b0};
        en[7:4]    = {1'b1,
                      keypad_irq_en_in[1],
                      timer_one_channel_en_in[1],
                      analog_channel_en_in[1]};
        oe[7:4]    = {pa_dir_q[1],
                      1'b0,
                      timer_one_channel_oe_in[1],
                      1'b0};
        dout[7:4]  = {pa_data_q[1],
                      1'b0,
                      timer_one_channel_out_in[1],
                      1'b0};
        // A2 is input only in every function [RQ3]
        en[11:8]   = {1'b1,
                      keypad_irq_en_in[2],
                      timer_one_ext_clock_en_in,
                      ext_irq_en_in};
        // A3 [RQ14]
        en[15:12]  = {1'b0,
                      1'b1,
                      keypad_irq_en_in[3],
                      reset_pin_en_in};
        oe[15:12]  = {1'b0,
                      pa_dir_q[3],
                      2'h0};
        dout[15:12] = {1'b0, pa_data_q[3], 2'h0};
        // A4 and A5 [RQ4]
        en[19:16]  = {1'b1,
                      keypad_irq_en_in[4],
                      analog_channel_en_in[2],
                      oscillator_output_en_in};
        oe[19:16]  = {pa_dir_q[4],
                      2'h0,
                      1'b1};
        dout[19:16] = {pa_data_q[4], 2'h0, oscillator_output_clk_in};
        en[23:20]  = {1'b1,
                      keypad_irq_en_in[5],
                      analog_channel_en_in[3],
                      oscillator_input_en_in};
        oe[23:20]  = {pa_dir_q[5],
                      3'h0};
        dout[23:20] = {pa_data_q[5], 3'h0};
        // B0 [RQ5]
        en[27:24]  = {1'b0,
                      1'b1,
                      spi_en_in,
                      analog_channel_en_in[4]};
        oe[27:24]  = {1'b0,
                      pb_dir_q[0],
                      serial_periph_clock_line_oe_in,
                      1'b0};
        dout[27:24] = {1'b0, pb_data_q[0], serial_periph_clock_line_out_in, 1'b0};
        // B1 and B2 [RQ6]
        en[31:28]  = {1'b1,
                      timer_two_channel_en_in[1] & t2_on_b12,
                      spi_en_in,
                      analog_channel_en_in[5]};
        oe[31:28]  = {pb_dir_q[1],
                      timer_two_channel_oe_in[1],
                      spi_mosi_oe_in,
                      1'b0};
        dout[31:28] = {pb_data_q[1], timer_two_channel_out_in[1], spi_mosi_out_in, 1'b0};
        en[35:32]  = {1'b1,
                      timer_two_channel_en_in[0] & t2_on_b12,
                      spi_en_in,
                      analog_channel_en_in[6]};
        oe[35:32]  = {pb_dir_q[2],
                      timer_two_channel_oe_in[0],
                      spi_miso_oe_in,
                      1'b0};
        dout[35:32] = {pb_data_q[2], timer_two_channel_out_in[0], spi_miso_out_in, 1'b0};
        // B3 [RQ7]
        en[39:36]  = {1'b1,
                      timer_two_ext_clock_en_in,
                      spi_slave_select_en_in,
                      analog_channel_en_in[7]};
        oe[39:36]  = {pb_dir_q[3],
                      3'h0};
        dout[39:36] = {pb_data_q[3], 3'h0};
        // B4 and B5 [RQ8]
        en[43:40]  = {1'b1,
                      timer_two_channel_en_in[0] & t2_on_b54,
                      async_serial_rx_en_in,
                      analog_channel_en_in[8]};
        oe[43:40]  = {pb_dir_q[4],
                      timer_two_channel_oe_in[0],
                      1'b0,
                      1'b0}; // [RQ9]
        dout[43:40] = {pb_data_q[4], timer_two_channel_out_in[0], 2'h0};
        en[47:44]  = {1'b1,
                      timer_two_channel_en_in[1] & t2_on_b54,
                      async_serial_tx_en_in,
                      analog_channel_en_in[9]};
        oe[47:44]  = {pb_dir_q[5],
                      timer_two_channel_oe_in[1],
                      1'b1,
                      1'b0}; // [RQ9]
        dout[47:44] = {pb_data_q[5], timer_two_channel_out_in[1], async_serial_tx_out_in, 1'b0};
        // B6 and B7 [RQ14]
        en[51:48]  = {2'h0,
                      1'b1,
                      timer_one_channel_en_in[2]};
        oe[51:48]  = {2'h0,
                      pb_dir_q[6],
                      timer_one_channel_oe_in[2]};
        dout[51:48] = {2'h0, pb_data_q[6], timer_one_channel_out_in[2]};
        en[55:52]  = {2'h0,
                      1'b1,
                      timer_one_channel_en_in[3]};
        oe[55:52]  = {2'h0,
                      pb_dir_q[7],
                      timer_one_channel_oe_in[3]};
        dout[55:52] = {2'h0, pb_data_q[7], timer_one_channel_out_in[3]};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // resolvers

    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1)
        begin : g_pin
            smp_pin_resolve #(
                .N           (NF),
                .ANALOG_MASK (ANA_MAP[4*g +: 4])
            ) u_res (
                .func_en_in  (en[NF*g +: NF]),
                .func_oe_in  (oe[NF*g +: NF]),
                .func_out_in (dout[NF*g +: NF]),
                .owner_out   (owner[2*g +: 2]),
                .pin_oe_out  (res_oe[g]),
                .pin_out     (res_out[g])
            ); // [RQ15]
        end
    endgenerate

    // no pin drives until the first cycle after reset release [RQ1]
    assign port_a_oe_out  = ready_q ? res_oe[5:0] : 6'h00;
    assign port_b_oe_out  = ready_q ? res_oe[13:6] : 8'h00;
    assign port_a_pin_out = ready_q ? res_out[5:0] : 6'h00;
    assign port_b_pin_out = ready_q ? res_out[13:6] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // special mode entry

    smp_hv_detect u_hv (
        .clock_in         (clock_in),
        .rst_in           (rst_in),
        .hv_a2_in         (port_a_bit_two_hv_in),
        .hv_c3_in         (port_c_bit_three_hv_in),
        .special_mode_out (special_mode_out)
    ); // [RQ12]

endmodule // smp_shared_pin_priority_mux

//--- bench/smp_pin_monitor.sv
// Purpose: port-level checks of the shared pin priority mux
// Assumes: pin drive is combinational and gated one cycle past reset
// Notes:   analog channels never block the lower slots from driving
`timescale 1ns/1ps
module smp_pin_monitor (
    input wire       clock_in,
    input wire       rst_in,
    input wire [3:0] timer_one_channel_en_in,
    input wire [3:0] timer_one_channel_oe_in,
    input wire [3:0] timer_one_channel_out_in,
    input wire       reset_pin_en_in,
    input wire       oscillator_output_en_in,
    input wire       oscillator_output_clk_in,
    input wire       oscillator_input_en_in,
    input wire       spi_en_in,
    input wire       serial_periph_clock_line_oe_in,
    input wire       async_serial_rx_en_in,
    input wire       async_serial_tx_en_in,
    input wire       async_serial_tx_out_in,
    input wire [5:0] port_a_pin_out,
    input wire [5:0] port_a_oe_out,
    input wire [7:0] port_b_pin_out,
    input wire [7:0] port_b_oe_out,
    input wire       port_a_bit_two_hv_in,
    input wire [1:0] special_mode_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    reset_gate_a: assert property ($fell(rst_in) |-> port_a_oe_out == 6'h00 && port_b_oe_out == 8'h00)
        else $error("pin driven on first edge after reset");
    a0_timer_a: assert property (!$past(rst_in) && timer_one_channel_en_in[0] |->
        port_a_oe_out[0] == timer_one_channel_oe_in[0] && port_a_pin_out[0] == timer_one_channel_out_in[0])
        else $error("timer one channel lost pin a0");
    a2_input_a: assert property (1'b1 |-> !port_a_oe_out[2])
        else $error("input only pin a2 driven");
    a3_reset_a: assert property (reset_pin_en_in |-> !port_a_oe_out[3])
        else $error("reset pin function driven");
    osc_drive_a: assert property (!$past(rst_in) && oscillator_output_en_in |->
        port_a_oe_out[4] && port_a_pin_out[4] == oscillator_output_clk_in)
        else $error("oscillator output not on a4");
    osc_input_a: assert property (oscillator_input_en_in |-> !port_a_oe_out[5])
        else $error("oscillator input pin driven");
    spi_clock_a: assert property (!$past(rst_in) && spi_en_in |->
        port_b_oe_out[0] == serial_periph_clock_line_oe_in)
        else $error("serial clock line lost pin b0");
    tx_drive_a: assert property (!$past(rst_in) && async_serial_tx_en_in |->
        port_b_oe_out[5] && port_b_pin_out[5] == async_serial_tx_out_in)
        else $error("transmit line not driven on b5");
    rx_input_a: assert property (async_serial_rx_en_in |-> !port_b_oe_out[4])
        else $error("receive pin driven");
    b6_timer_a: assert property (!$past(rst_in) && timer_one_channel_en_in[2] |->
        port_b_oe_out[6] == timer_one_channel_oe_in[2])
        else $error("timer one channel lost pin b6");
    hv_sticky_a: assert property (port_a_bit_two_hv_in |=> special_mode_out[0] [*4])
        else $error("special mode flag not held");
endmodule // smp_pin_monitor
bind smp_shared_pin_priority_mux smp_pin_monitor mon_u (.*);

//--- bench/smp_pin_board.sv
// Purpose: board side of the shared pins
// Assumes: every pin has a pull-up on the board
// Notes:   a pin the block does not drive reads high
`timescale 1ns/1ps
module smp_pin_board (
    input  wire [5:0] port_a_pin_out,
    input  wire [5:0] port_a_oe_out,
    input  wire [7:0] port_b_pin_out,
    input  wire [7:0] port_b_oe_out,
    output wire [5:0] port_a_pin_in,
    output wire [7:0] port_b_pin_in
);
    assign port_a_pin_in = (port_a_oe_out & port_a_pin_out) | ~port_a_oe_out;
    assign port_b_pin_in = (port_b_oe_out & port_b_pin_out) | ~port_b_oe_out;
endmodule // smp_pin_board

//--- bench/smp_shared_pin_priority_mux_tb_top.sv
// Purpose: directed tests of the shared pin priority mux
// Assumes: register port with read data one cycle after the strobe
// Notes:   owner codes are read back through the owner registers
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; $display("ERROR %0t mismatch got %h exp %h", $time, a, e); end end
module smp_shared_pin_priority_mux_tb_top;
    logic       clock_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
    logic [3:0] addr_in = 0;
    logic [7:0] wdata_in = 0;
    logic [9:0] analog_channel_en_in = 0;
    logic [5:0] keypad_irq_en_in = 0;
    logic [3:0] timer_one_channel_en_in = 0, timer_one_channel_oe_in = 4'hf, timer_one_channel_out_in = 4'hf;
    logic [1:0] timer_two_channel_en_in = 0, timer_two_channel_oe_in = 2'h3, timer_two_channel_out_in = 2'h3;
    logic       timer_one_ext_clock_en_in = 0, timer_two_ext_clock_en_in = 0, ext_irq_en_in = 0, reset_pin_en_in = 0;
    logic       oscillator_output_en_in = 1, oscillator_output_clk_in = 0, oscillator_input_en_in = 0, spi_en_in = 0;
    logic       serial_periph_clock_line_oe_in = 0, serial_periph_clock_line_out_in = 0, spi_slave_select_en_in = 0;
    logic       spi_mosi_oe_in = 0, spi_mosi_out_in = 0, spi_miso_oe_in = 0, spi_miso_out_in = 0;
    logic       async_serial_rx_en_in = 0, async_serial_tx_en_in = 0, async_serial_tx_out_in = 0;
    logic       port_a_bit_two_hv_in = 0, port_c_bit_three_hv_in = 0;
    wire  [7:0] rdata_out, port_b_pin_out, port_b_oe_out, port_b_pin_in;
    wire  [5:0] port_a_pin_out, port_a_oe_out, port_a_pin_in;
    wire  [1:0] special_mode_out;
    int         err_count = 0, check_count = 0;
    logic [3:0] own_addr [5] = '{4'h6, 4'h6, 4'h7, 4'h8, 4'h8};
    int         own_sh [5] = '{0, 4, 0, 2, 4};
    logic [7:0] own_base [5] = '{8'hbc, 8'h8f, 8'hec, 8'hf3, 8'hcf};

    smp_shared_pin_priority_mux dut_u (.*);
    smp_pin_board board_u (.*);

    always #20 clock_in = ~clock_in;
    always @(posedge clock_in) oscillator_output_clk_in <= ~oscillator_output_clk_in;

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        @(negedge clock_in);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        `CHK(rdata_out, e)
    endtask
    // walks the slots of one pin from the highest enabled down to the port
    task automatic own(input int w);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock_in);
            case (w)
                0: {analog_channel_en_in[0], timer_one_channel_en_in[0], keypad_irq_en_in[0]} <= {i == 0, i <= 1, i <= 2};
                1: {ext_irq_en_in, timer_one_ext_clock_en_in, keypad_irq_en_in[2]} <= {i == 0, i <= 1, i <= 2};
                2: {oscillator_output_en_in, analog_channel_en_in[2], keypad_irq_en_in[4]} <= {i == 0, i <= 1, i <= 2};
                3: {analog_channel_en_in[7], spi_slave_select_en_in, timer_two_ext_clock_en_in} <= {i == 0, i <= 1, i <= 2};
                default: {analog_channel_en_in[8], async_serial_rx_en_in, timer_two_channel_en_in[0]} <= {i == 0, i <= 1, i <= 2};
            endcase
            rchk(own_addr[w], own_base[w] | (i[7:0] << own_sh[w]));
            `CHK((rdata_out >> own_sh[w]) & 8'h03, i[7:0])
        end
        $display("test owner %0d done", w);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clock_in);
        `CHK(port_a_oe_out, 6'h00)
        rst_in <= 1'b0;
        oscillator_output_en_in <= 1'b0;
        rchk(4'h1, 8'h00);
        own(0);
        own(1);
        own(2);
        own(3);
        wr(4'h4, 8'h01);
        own(4);
        @(posedge clock_in);
        timer_two_channel_en_in <= 2'h3;
        @(negedge clock_in);
        `CHK({port_b_oe_out[5:4], port_b_oe_out[2:1]}, 4'b1100)
        wr(4'h4, 8'h00);
        `CHK({port_b_oe_out[5:4], port_b_oe_out[2:1]}, 4'b0011)
        @(posedge clock_in);
        {spi_en_in, serial_periph_clock_line_oe_in, analog_channel_en_in[4]} <= 3'b111;
        @(negedge clock_in);
        `CHK(port_b_oe_out[2:0], 3'b001)
        rchk(4'h7, 8'h4f);
        @(posedge clock_in);
        {spi_en_in, timer_two_channel_en_in, analog_channel_en_in} <= 13'h0000;
        $display("test relocate and serial done");
        {async_serial_tx_en_in, async_serial_rx_en_in, oscillator_input_en_in, reset_pin_en_in} <= 4'hf;
        timer_one_channel_en_in[2] <= 1'b1;
        wr(4'h1, 8'h3f);
        wr(4'h3, 8'hff);
        `CHK(port_a_oe_out, 6'h13)
        `CHK(port_b_oe_out, 8'hef)
        `CHK(port_b_pin_out, 8'h40)
        rchk(4'h5, 8'h2c);
        wr(4'hc, 8'hff);
        rchk(4'hc, 8'h00);
        $display("test functions done");
        @(posedge clock_in);
        port_a_bit_two_hv_in <= 1'b1;
        @(posedge clock_in);
        port_a_bit_two_hv_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        `CHK(special_mode_out, 2'b01)
        port_c_bit_three_hv_in <= 1'b1;
        @(posedge clock_in);
        port_c_bit_three_hv_in <= 1'b0;
        rchk(4'hb, 8'h03);
        @(posedge clock_in);
        rst_in <= 1'b1;
        @(negedge clock_in);
        `CHK(port_b_oe_out, 8'h00)
        @(posedge clock_in);
        rst_in <= 1'b0;
        rchk(4'h3, 8'h00);
        $display("test second reset done");
        end_sim;
    end

    initial
    begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        end_sim;
    end
endmodule // smp_shared_pin_priority_mux_tb_top
